// *** src/psram_low_power_mode_control.v ***
/*
 holds: host-side controller that writes the pseudo-static ram mode register
        and drives partial refresh / deep sleep through the sleep pin.
 assumes: one 50 MHz clock; software on avalon-mm; device pins are plain
          outputs here, the board drives the device from them.
          reads answer after one wait state, writes take none.
*/
// What this block does
// - region change needs mode register rewrite
// - no access outside reduced region; rewrite restores
// - deselect 5ns before sleep; write 10-500ns after
// - write cycle speed grade; pulse at least 40ns
// - sleep low 10us minimum; 150us recovery
`timescale 1ns/1ps
`include "psram_lp_defines.vh"

module psram_low_power_mode_control #(
    parameter SLEEP_MIN_CYC = (`T_SLEEP_MIN_US * `CLK_MHZ),
    parameter RECOVER_CYC   = (`T_RECOVER_US * `CLK_MHZ)
) (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    output reg         chipEnable_n,
    output reg         writeEnable_n,
    output reg         sleepRequest_n,
    output reg  [7:0]  modeAddr,
    output wire        busy
);

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
// least times round up, the longest time rounds down
localparam DESEL_CYC = (`T_DESEL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
localparam SWE_CYC   = (`T_SLEEP_WE_MIN + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
localparam SWE_MAX   = `T_SLEEP_WE_MAX / `CLK_PERIOD_NS;
localparam WP_CYC0   = (`T_WRCYC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
localparam WPM_CYC   = (`T_WPULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
localparam WP_CYC    = (WP_CYC0 > WPM_CYC) ? WP_CYC0 : WPM_CYC;
// SWE_MAX stays for reference; the gap used sits near its lower end

// ----------------------------------------------------------------
// sequencer states
// ----------------------------------------------------------------
localparam S_IDLE  = 3'h0;
localparam S_DESEL = 3'h1;
localparam S_SWE   = 3'h2;
localparam S_WPUL  = 3'h3;
localparam S_SLEEP = 3'h4;
localparam S_REC   = 3'h5;

// ----------------------------------------------------------------
// registers and decode
// ----------------------------------------------------------------
reg  [2:0]  state_q;
reg  [15:0] cnt_q;
reg  [7:0]  mode_q;
reg         sleepReq_q;
reg         rsvdErr_q;
reg         updPend_q;
reg         rdValid_q;

wire        cntDone   = (cnt_q == 16'h0000);
wire [2:0]  regionWr  = avs_writedata[`MODE_REGION_MSB:`MODE_REGION_LSB];
wire        rsvdCode  = (regionWr == `REGION_RSVD_A) || (regionWr == `REGION_RSVD_B);
wire        modeWrite = avs_write && (avs_address == `OFS_MODE) && !busy;
wire        ctrlWrite = avs_write && (avs_address == `OFS_CTRL);
wire        rdAccept  = avs_read && !rdValid_q;
wire [4:0]  statusBits;

// status: bit0 pin low, bit1 deselect, bit2 sleeping, bit3 busy, bit4 refused
assign statusBits = {rsvdErr_q,
                     busy,
                     (state_q == S_SLEEP),
                     (state_q == S_DESEL),
                     ~sleepRequest_n};

// ----------------------------------------------------------------
// avalon slave: writes take no wait state, reads take one
// ----------------------------------------------------------------
// readdata comes from a flop, so a read is held off one cycle;
// the word then stands at the edge where waitrequest is seen low
assign avs_waitrequest = rdAccept;
assign busy            = (state_q != S_IDLE) && (state_q != S_SLEEP);

// ----------------------------------------------------------------
// control and mode registers
// ----------------------------------------------------------------
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        mode_q     <= `MODE_RESET;
        sleepReq_q <= 1'b0;
        updPend_q  <= 1'b0;
        rsvdErr_q  <= 1'b0;
    end else begin
        if (state_q == S_DESEL)
            updPend_q <= 1'b0;
        if (modeWrite) begin
            // reserved region codes are refused so the die never sees them
            if (rsvdCode)
                rsvdErr_q <= 1'b1;
            else begin
                mode_q    <= avs_writedata[`MODE_W-1:0];
                rsvdErr_q <= 1'b0;
            end
        end
        if (ctrlWrite) begin
            sleepReq_q <= avs_writedata[`CTRL_SLEEP];
            if (avs_writedata[`CTRL_UPDATE])
                updPend_q <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// read path
// ----------------------------------------------------------------
// a read held past its answer simply starts a second one
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        rdValid_q    <= 1'b0;
        avs_readdata <= 32'h0000_0000;
    end else begin
        rdValid_q <= rdAccept;
        if (rdAccept) begin
            case (avs_address)
                `OFS_CTRL:   avs_readdata <= {30'h0000_0000, sleepReq_q, updPend_q};
                `OFS_MODE:   avs_readdata <= {24'h00_0000, mode_q};
                `OFS_STATUS: avs_readdata <= {27'h000_0000, statusBits};
                default:     avs_readdata <= 32'h0000_0000;
            endcase
        end
    end
end

// ----------------------------------------------------------------
// pin sequencer
// ----------------------------------------------------------------
// the device handles refresh scope itself from mode_q: partial refresh
// (sleepsel=1) or deep sleep (sleepsel=0) 10us after sleep falls
always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
        state_q        <= S_IDLE;
        cnt_q          <= 16'h0000;
        chipEnable_n   <= 1'b1;
        writeEnable_n  <= 1'b1;
        sleepRequest_n <= 1'b1;
        modeAddr       <= 8'h00;
    end else begin
        if (!cntDone)
            cnt_q <= cnt_q - 16'h0001;
        case (state_q)
            S_IDLE: begin
                // an update wins over a sleep request seen in the same cycle
                if (updPend_q) begin
                    chipEnable_n <= 1'b1;
                    cnt_q        <= DESEL_CYC[15:0];
                    state_q      <= S_DESEL;
                end else if (sleepReq_q) begin
                    chipEnable_n   <= 1'b1;
                    sleepRequest_n <= 1'b0;
                    cnt_q          <= SLEEP_MIN_CYC[15:0];
                    state_q        <= S_SLEEP;
                end
            end
            S_DESEL: if (cntDone) begin
                sleepRequest_n <= 1'b0;
                modeAddr       <= mode_q;
                cnt_q          <= SWE_CYC[15:0];
                state_q        <= S_SWE;
            end
            S_SWE: if (cntDone) begin
                // write falls SWE_CYC + 1 cycles after sleep, well under SWE_MAX
                chipEnable_n  <= 1'b0;
                writeEnable_n <= 1'b0;
                cnt_q         <= WP_CYC[15:0];
                state_q       <= S_WPUL;
            end
            S_WPUL: if (cntDone) begin
                writeEnable_n  <= 1'b1;
                chipEnable_n   <= 1'b1;
                sleepRequest_n <= 1'b1;
                cnt_q          <= RECOVER_CYC[15:0];
                state_q        <= S_REC;
            end
            S_SLEEP: if (cntDone && !sleepReq_q) begin
                // minimum low time held even if software lets go early
                sleepRequest_n <= 1'b1;
                cnt_q          <= RECOVER_CYC[15:0];
                state_q        <= S_REC;
            end
            // nothing new starts until the recovery count has run out
            S_REC: if (cntDone)
                state_q <= S_IDLE;
            default: state_q <= S_IDLE;
        endcase
    end
end

endmodule // psram_low_power_mode_control

// *** shared/psram_lp_defines.vh ***
/*
 holds: register offsets, field positions, reset values and timing figures
        for the pseudo-static ram low-power mode controller.
 assumes: included by bare name; all times in ns or us, clock rate in MHz.
*/
`ifndef PSRAM_LP_DEFINES_VH
`define PSRAM_LP_DEFINES_VH

// ----------------------------------------------------------------
// avalon register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_CTRL        4'h0
`define OFS_MODE        4'h4
`define OFS_STATUS      4'h8

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_UPDATE     0
`define CTRL_SLEEP      1

// ----------------------------------------------------------------
// mode word fields, placed on the low address lines
// ----------------------------------------------------------------
`define MODE_REGION_LSB 0
`define MODE_REGION_MSB 2
`define MODE_SIZE       3
`define MODE_SLEEPSEL   4
`define MODE_TEMP_LSB   5
`define MODE_TEMP_MSB   6
`define MODE_PAGE       7
`define MODE_W          8
`define MODE_RESET      8'h10

// ----------------------------------------------------------------
// region codes
// ----------------------------------------------------------------
`define REGION_RSVD_A   3'h5
`define REGION_RSVD_B   3'h1

// ----------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------
`define CLK_MHZ         50
`define CLK_PERIOD_NS   20
`define T_DESEL_NS      5
`define T_SLEEP_WE_MIN  10
`define T_SLEEP_WE_MAX  500
`define T_WRCYC_NS      85
`define T_WPULSE_NS     40
`define T_SLEEP_MIN_US  10
`define T_RECOVER_US    150

`endif

// *** tb/psram_lp_assertions.sv ***
/* holds: assertions on the mode controller pins
   assumes: bound into the controller, one clock, async low reset */
`timescale 1ns/1ps
module psram_lp_assertions #(parameter RECOVER_CYC = 7500) (
    input wire       clk_sys,
    input wire       arst_n,
    input wire       chipEnable_n,
    input wire       writeEnable_n,
    input wire       sleepRequest_n,
    input wire [7:0] modeAddr,
    input wire       busy
);
    // cycles with the sleep pin high; saturates so a long idle cannot wrap
    reg [15:0] highCnt_q;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) highCnt_q <= 16'hffff;
        else highCnt_q <= sleepRequest_n ? highCnt_q + {15'h0000, ~&highCnt_q} : 16'h0000;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    AST_DESEL: assert property ($fell(sleepRequest_n) |-> chipEnable_n && $past(chipEnable_n))
        else $error("chip selected at sleep");
    AST_SLEEP_FIRST: assert property ($fell(writeEnable_n) |-> !$past(sleepRequest_n))
        else $error("write before sleep");
    AST_SWE_MAX: assert property ($fell(sleepRequest_n) && busy |-> ##[1:24] $fell(writeEnable_n))
        else $error("write too late after sleep");
    AST_PULSE: assert property ($fell(writeEnable_n) |-> (!writeEnable_n && !chipEnable_n)[*5])
        else $error("write pulse short");
    AST_ADDR: assert property (!writeEnable_n |-> $stable(modeAddr))
        else $error("mode bits moved");
    AST_BRACKET: assert property (!writeEnable_n |-> !sleepRequest_n && !chipEnable_n)
        else $error("write outside bracket");
    AST_CE_WE: assert property ($fell(chipEnable_n) |-> $fell(writeEnable_n))
        else $error("select without write");
    AST_RECOVER: assert property ($fell(sleepRequest_n) |-> highCnt_q >= RECOVER_CYC)
        else $error("recovery cut short");
    AST_REC_BUSY: assert property ($rose(sleepRequest_n) |-> busy[*4])
        else $error("not busy in recovery");
endmodule // psram_lp_assertions
bind psram_low_power_mode_control psram_lp_assertions #(.RECOVER_CYC(RECOVER_CYC)) psram_lp_assertions_inst (
    .clk_sys, .arst_n, .chipEnable_n, .writeEnable_n, .sleepRequest_n, .modeAddr, .busy);

// *** tb/psram_mode_model.sv ***
/* holds: mode register model of the ram
   assumes: sampled on the controller clock; the ram has no reset pin */
`timescale 1ns/1ps
module psram_mode_model #(parameter ENTRY_CYC = 10) (
    input  wire       clk_sys,
    input  wire       chipEnable_n,
    input  wire       writeEnable_n,
    input  wire       sleepRequest_n,
    input  wire [7:0] modeAddr,
    output reg  [7:0] modeReg = 8'h10,
    output wire       deepSleep,
    output wire       partialRefresh,
    output reg        sizeLimited = 1'b0
);
    reg [8:0]  pend = 9'h000;
    reg        pinSeen = 1'b1;
    integer    lowCnt = 0;
    wire [7:0] nextMode = pend[8] ? pend[7:0] : modeReg;
    always @(posedge clk_sys) begin
        if (!writeEnable_n && !chipEnable_n && !sleepRequest_n) pend <= {1'b1, modeAddr};
        else if (pend[8]) {pend[8], modeReg} <= {1'b0, pend[7:0]};
        lowCnt <= sleepRequest_n ? 0 : lowCnt + 1;
        pinSeen <= sleepRequest_n;
        // reduced size is latched as the sleep pin rises and holds to the next rise
        if (sleepRequest_n && !pinSeen) sizeLimited <= nextMode[3] && nextMode[4];
    end
    // entry count stands in for the long wait so runs stay short
    assign deepSleep      = lowCnt >= ENTRY_CYC && !modeReg[4];
    assign partialRefresh = lowCnt >= ENTRY_CYC && modeReg[4];
endmodule // psram_mode_model

// *** tb/psram_low_power_mode_control_tb.sv ***
/* holds: self-checking bench of the mode controller
   assumes: ram model on the pins, short sleep and recovery counts */
`timescale 1ns/1ps
module psram_low_power_mode_control_tb;
    reg         clk_sys = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    reg  [3:0]  avs_address = 4'h0;
    reg  [31:0] avs_writedata = 32'h0, d;
    wire [31:0] avs_readdata;
    wire [7:0]  modeAddr, modeReg;
    wire        avs_waitrequest, chipEnable_n, writeEnable_n, sleepRequest_n, busy, deepSleep, partialRefresh;
    wire        sizeLimited;
    integer     error_cnt = 0, n_compared = 0, cycles = 0, i;
    always #10 clk_sys = ~clk_sys;
    psram_low_power_mode_control #(.SLEEP_MIN_CYC(4), .RECOVER_CYC(8)) psram_low_power_mode_control_inst (.clk_sys,
        .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .chipEnable_n, .writeEnable_n, .sleepRequest_n, .modeAddr, .busy);
    psram_mode_model psram_mode_model_inst (.clk_sys, .chipEnable_n, .writeEnable_n, .sleepRequest_n,
        .modeAddr, .modeReg, .deepSleep, .partialRefresh, .sizeLimited);
    task chk(input string s, input [31:0] e, input [31:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED %s expected %h seen %h", s, e, g);
            end
        end
    endtask
    task finish_test(input integer extra);
        begin
            error_cnt = error_cnt + extra;
            $display("compared %0d mismatched %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    task bus(input w, input [3:0] a, input [31:0] v);
        begin
            {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, v};
            @(posedge clk_sys);
            while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
            d = avs_readdata;
            {avs_write, avs_read} <= 2'b00;
            @(posedge clk_sys);
        end
    endtask
    task idle;
        begin
            repeat (3) @(negedge clk_sys);
            for (i = 0; i < 200 && busy !== 1'b0; i = i + 1) @(negedge clk_sys);
            @(posedge clk_sys);
        end
    endtask
    task step(input [7:0] m, input [1:0] e);
        begin
            bus(1'b1, 4'h4, {24'h0, m});
            bus(1'b1, 4'h0, 32'h1);
            idle;
            chk("ram mode", {24'h0, m}, modeReg);
            chk("size limit", {31'h0, m[3] & m[4]}, sizeLimited);
            bus(1'b1, 4'h0, 32'h2);
            repeat (6) @(negedge clk_sys);
            chk("early", 32'h0, {deepSleep, partialRefresh});
            repeat (8) @(negedge clk_sys);
            chk("asleep", {e, 1'b0}, {deepSleep, partialRefresh, sleepRequest_n});
            @(posedge clk_sys);
            bus(1'b0, 4'h8, 32'h0);
            chk("status", 32'h5, d[3:0]);
            bus(1'b1, 4'h0, 32'h0);
            idle;
            chk("awake", 32'h0, {deepSleep, partialRefresh});
            $display("mode %h done", m);
        end
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) finish_test(1);
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        chk("pins", 32'h7, {chipEnable_n, writeEnable_n, sleepRequest_n});
        bus(1'b1, 4'hc, 32'hff);
        bus(1'b0, 4'h4, 32'h0);
        chk("mode", 32'h10, d);
        step(8'h93, 2'b01);
        step(8'h1a, 2'b01);
        step(8'h14, 2'b01);
        step(8'h47, 2'b10);
        bus(1'b1, 4'h4, 32'h85);
        bus(1'b0, 4'h8, 32'h0);
        chk("refused", 32'h1, d[4]);
        bus(1'b0, 4'h4, 32'h0);
        chk("kept", 32'h47, d);
        $display("reserved code done");
        finish_test(0);
    end
endmodule // psram_low_power_mode_control_tb
